// File: hw/rtcli_pkg.sv
package rtcli_pkg;

  // Host side register addresses on the special function register bus.
  localparam logic [7:0] RTCLI_KEY_ADDR = 8'hAE;
  localparam logic [7:0] RTCLI_ADR_ADDR = 8'hAC;
  localparam logic [7:0] RTCLI_DAT_ADDR = 8'hAD;

  // Unlock key bytes, in the order they must arrive.
  localparam logic [7:0] RTCLI_KEY_FIRST = 8'hA5;
  localparam logic [7:0] RTCLI_KEY_SECOND = 8'hF1;

  // Status codes returned by a read of the lock/key port.
  localparam logic [7:0] RTCLI_ST_LOCKED = 8'h00;
  localparam logic [7:0] RTCLI_ST_FIRST = 8'h01;
  localparam logic [7:0] RTCLI_ST_OPEN = 8'h02;
  localparam logic [7:0] RTCLI_ST_DISABLED = 8'h03;

  // Field positions and reset values of the indirect address and data ports.
  localparam int RTCLI_BUSY_BIT = 7;
  localparam int RTCLI_AUTO_READ_ENABLE_BIT = 6;
  localparam int RTCLI_SHORT_BIT = 4;
  localparam int RTCLI_ADDR_W = 4;
  localparam logic RTCLI_SHORT_RST = 1'b1;
  localparam logic RTCLI_AUTO_READ_ENABLE_RST = 1'b0;
  localparam logic [3:0] RTCLI_ADDR_RST = 4'h0;
  localparam logic [7:0] RTCLI_DATA_RST = 8'h00;

  // Indirect access length in system clock cycles.
  localparam logic [2:0] RTCLI_ACC_LONG = 3'h7;
  localparam logic [2:0] RTCLI_ACC_SHORT = 3'h6;

  // Internal register map.
  localparam logic [3:0] RTCLI_SNAP_LO = 4'h0;
  localparam logic [3:0] RTCLI_SNAP_HI = 4'h3;
  localparam logic [3:0] RTCLI_CLK_CTRL = 4'h4;
  localparam logic [3:0] RTCLI_OSC_CTRL = 4'h5;
  localparam logic [3:0] RTCLI_OSC_CFG = 4'h6;
  localparam logic [3:0] RTCLI_PIN_CFG = 4'h7;
  localparam logic [3:0] RTCLI_ALARM_LO = 4'h8;
  localparam logic [3:0] RTCLI_ALARM_HI = 4'hB;
  localparam int RTCLI_NUM_REGS = 12;
  localparam logic [7:0] RTCLI_BANK_RST = 8'h00;

  // States of the lock and key sequence.
  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_FIRST,
    LOCK_OPEN,
    LOCK_DEAD
  } rtcli_lock_t;

endpackage : rtcli_pkg

// File: hw/rtcli_bank_if.sv
`timescale 1ns/1ps
// Carries one indirect transfer between the access engine and the bank.
interface rtcli_bank_if;
  logic wr;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr, output addr, output wdata, input rdata);
  modport bank (input wr, input addr, input wdata, output rdata);
endinterface : rtcli_bank_if

// File: hw/rtcli_reg_bank.sv
`timescale 1ns/1ps
module rtcli_reg_bank
  import rtcli_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  rtcli_bank_if.bank bus,
  input wire logic capture_i,
  input wire logic [31:0] counter_i,
  output logic [31:0] counter_snapshot_o,
  output logic [7:0] clock_control_o,
  output logic [7:0] oscillator_control_o,
  output logic [7:0] oscillator_config_o,
  output logic [7:0] pin_config_o,
  output logic [31:0] alarm_value_o
);

  logic [7:0] regs_q [RTCLI_NUM_REGS];

  ////////////////////////////////////////////////////////////////////////
  // One byte register per entry; the snapshot bytes also load from the counter on a capture.
  for (genvar i = 0; i < RTCLI_NUM_REGS; i++) begin : g_byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        regs_q[i] <= RTCLI_BANK_RST;
      end else if (ce_i) begin
        if (bus.wr && bus.addr == 4'(i)) begin
          regs_q[i] <= bus.wdata; // Host write wins over a capture.
        end else if (capture_i && 4'(i) <= RTCLI_SNAP_HI) begin
          regs_q[i] <= counter_i[8*(i%4) +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port; addresses above the map read as zero.
  // R19 internal map
  always_comb begin
    if (bus.addr <= RTCLI_ALARM_HI) begin
      bus.rdata = regs_q[bus.addr];
    end else begin
      bus.rdata = 8'h00;
    end
  end

  // Register contents toward the clock core.
  assign counter_snapshot_o = {regs_q[3], regs_q[2], regs_q[1], regs_q[0]};
  assign clock_control_o = regs_q[RTCLI_CLK_CTRL];
  assign oscillator_control_o = regs_q[RTCLI_OSC_CTRL];
  assign oscillator_config_o = regs_q[RTCLI_OSC_CFG];
  assign pin_config_o = regs_q[RTCLI_PIN_CFG];
  assign alarm_value_o = {regs_q[11], regs_q[10], regs_q[9], regs_q[8]};

endmodule : rtcli_reg_bank

// File: hw/rtcli_top.sv
// Behaviour
// R1 - Unlock only after key A5 then key F1 are written to lock/key port.
// R2 - No timing limit between the two key writes; only order matters.
// R3 - Bad key, wrong order or locked access disables until system reset.
// R4 - Unlocked interface accepts any number of indirect accesses.
// R5 - Any lock/key write while unlocked locks the interface again.
// R6 - Reading lock/key port returns status and leaves sequence undisturbed.
// R7 - Address port selects internal register for following indirect accesses.
// R8 - Data port write starts indirect write of that byte to selected register.
// R9 - Writing one to busy bit starts indirect read into data port.
// R10 - Data port keeps read byte until next indirect read or write begins.
// R11 - Host polls busy low before each access unless following spacing.
// R12 - Address and data ports keep contents across a device reset; the code sets the short bit back to one on a system reset.
// R13 - Indirect access takes 7 cycles, or 6 with short strobe.
// R14 - Short strobe on after reset; address port bit four switches it.
// R15 - With autoread, each data port read starts the next indirect read.
// R16 - Autoread follows bit six of the address port.
// R17 - Host sets busy once at the start of an autoread series.
// R18 - Address auto-increments after accesses to snapshot or alarm bytes.
// R19 - Map: snapshot 0-3, control 4-7 as listed, alarm 8-B.
// R20 - Internal registers reachable only through address and data ports.
// R21 - Host waits three slots between address write and data read.
// R22 - Host leaves one idle slot after an indirect write.
// R23 - Busy reads one from access start until the access completes.
`timescale 1ns/1ps
module rtcli_top
  import rtcli_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic capture_i,
  input wire logic [31:0] counter_i,
  output logic [31:0] counter_snapshot_o,
  output logic [7:0] clock_control_o,
  output logic [7:0] oscillator_control_o,
  output logic [7:0] oscillator_config_o,
  output logic [7:0] pin_config_o,
  output logic [31:0] alarm_value_o
);

  rtcli_lock_t lock_q;
  rtcli_lock_t lock_d;
  logic busy_q;
  logic op_wr_q;
  logic [2:0] cnt_q;
  logic short_q;
  logic auto_q;
  logic [3:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] rdata_q;
  logic key_wr;
  logic key_rd;
  logic adr_wr;
  logic adr_rd;
  logic dat_wr;
  logic dat_rd;
  logic port_acc;
  logic is_open;
  logic idle_open;
  logic wr_start;
  logic rd_start;
  logic start;
  logic short_nx;
  logic xfer;
  logic auto_inc;
  logic [7:0] adr_view;
  logic [7:0] key_view;

  rtcli_bank_if bank_if ();

  ////////////////////////////////////////////////////////////////////////
  // Bus decode of the three host side ports; write wins over read.
  assign key_wr = sfr_wr_i && sfr_addr_i == RTCLI_KEY_ADDR;
  assign key_rd = !sfr_wr_i && sfr_rd_i && sfr_addr_i == RTCLI_KEY_ADDR;
  assign adr_wr = sfr_wr_i && sfr_addr_i == RTCLI_ADR_ADDR;
  assign adr_rd = !sfr_wr_i && sfr_rd_i && sfr_addr_i == RTCLI_ADR_ADDR;
  assign dat_wr = sfr_wr_i && sfr_addr_i == RTCLI_DAT_ADDR;
  assign dat_rd = !sfr_wr_i && sfr_rd_i && sfr_addr_i == RTCLI_DAT_ADDR;
  assign port_acc = adr_wr || adr_rd || dat_wr || dat_rd;
  assign is_open = lock_q == LOCK_OPEN;
  assign idle_open = is_open && !busy_q;

  ////////////////////////////////////////////////////////////////////////
  // Lock and key sequence.
  always_comb begin
    lock_d = lock_q;
    unique case (lock_q)
      // R1 first key byte
      LOCK_IDLE: begin
        if (key_wr) begin
          // R3 wrong first key
          lock_d = (sfr_wdata_i == RTCLI_KEY_FIRST) ? LOCK_FIRST : LOCK_DEAD;
        end else if (port_acc) begin
          lock_d = LOCK_DEAD;
        end
      end
      // R2 no timeout here
      LOCK_FIRST: begin
        if (key_wr) begin
          // R1 second key byte
          lock_d = (sfr_wdata_i == RTCLI_KEY_SECOND) ? LOCK_OPEN : LOCK_DEAD;
        end else if (port_acc) begin
          lock_d = LOCK_DEAD;
        end
      end
      // R5 relock on write
      LOCK_OPEN: begin
        if (key_wr) begin
          lock_d = LOCK_IDLE;
        end
      end
      // R3 dead until reset
      LOCK_DEAD: begin
        lock_d = LOCK_DEAD;
      end
    endcase
  end

  // Lock state; only a system reset leaves the disabled state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q <= LOCK_IDLE;
    end else if (ce_i) begin
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start of indirect accesses; a busy interface ignores new ones.
  // R8 data write start
  assign wr_start = dat_wr && idle_open;
  // R9 busy bit read
  // R15 autoread start
  assign rd_start = idle_open &&
                    ((adr_wr && sfr_wdata_i[RTCLI_BUSY_BIT]) ||
                     (dat_rd && auto_q));
  // R4 no access limit
  assign start = wr_start || rd_start;
  // The short bit written together with busy applies to that same read.
  assign short_nx = (adr_wr && idle_open) ?
                    sfr_wdata_i[RTCLI_SHORT_BIT] : short_q;
  assign xfer = busy_q && cnt_q == 3'h1;
  // R18 snapshot and alarm
  assign auto_inc = addr_q <= RTCLI_SNAP_HI ||
                    (addr_q >= RTCLI_ALARM_LO && addr_q <= RTCLI_ALARM_HI);

  ////////////////////////////////////////////////////////////////////////
  // Access timer and busy flag.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      op_wr_q <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        // R23 busy set
        busy_q <= 1'b1;
        op_wr_q <= wr_start;
        // R13 access length
        cnt_q <= short_nx ? RTCLI_ACC_SHORT : RTCLI_ACC_LONG;
      end else if (busy_q) begin
        // R23 busy cleared
        cnt_q <= cnt_q - 3'h1;
        busy_q <= cnt_q != 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Short strobe control, back on after every system reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // R14 short after reset
      short_q <= RTCLI_SHORT_RST;
    end else if (ce_i && adr_wr && idle_open) begin
      // R14 short bit write
      short_q <= sfr_wdata_i[RTCLI_SHORT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address and autoread; cleared only at power on, not by system reset.
  // R12 retained address
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      addr_q <= RTCLI_ADDR_RST;
      auto_q <= RTCLI_AUTO_READ_ENABLE_RST;
    end else if (ce_i) begin
      if (adr_wr && idle_open) begin
        // R7 select target
        addr_q <= sfr_wdata_i[RTCLI_ADDR_W-1:0];
        // R16 autoread bit
        auto_q <= sfr_wdata_i[RTCLI_AUTO_READ_ENABLE_BIT];
      end else if (xfer && auto_inc) begin
        // R18 address increment
        addr_q <= addr_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data port; also retained across a system reset.
  // R12 retained data
  // R10 held until access
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      data_q <= RTCLI_DATA_RST;
    end else if (ce_i) begin
      if (wr_start) begin
        data_q <= sfr_wdata_i;
      end else if (xfer && !op_wr_q) begin
        // R9 copy into data
        data_q <= bank_if.rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port to the internal register bank, reachable only from here.
  // R20 indirect only
  assign bank_if.wr = xfer && op_wr_q;
  assign bank_if.addr = addr_q;
  assign bank_if.wdata = data_q;

  rtcli_reg_bank u_bank (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .bus(bank_if.bank),
    .capture_i(capture_i),
    .counter_i(counter_i),
    .counter_snapshot_o(counter_snapshot_o),
    .clock_control_o(clock_control_o),
    .oscillator_control_o(oscillator_control_o),
    .oscillator_config_o(oscillator_config_o),
    .pin_config_o(pin_config_o),
    .alarm_value_o(alarm_value_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read views of the lock/key and address ports.
  always_comb begin
    unique case (lock_q)
      LOCK_IDLE: key_view = RTCLI_ST_LOCKED;
      LOCK_FIRST: key_view = RTCLI_ST_FIRST;
      LOCK_OPEN: key_view = RTCLI_ST_OPEN;
      LOCK_DEAD: key_view = RTCLI_ST_DISABLED;
    endcase
  end

  // Unused bit five reads as zero.
  assign adr_view = {busy_q, auto_q, 1'b0, short_q, addr_q};

  // Read data, registered; a port that cannot be reached reads zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i && sfr_rd_i && !sfr_wr_i) begin
      if (key_rd) begin
        // R6 status read
        rdata_q <= key_view;
      end else if (adr_rd && is_open) begin
        rdata_q <= adr_view;
      end else if (dat_rd && is_open) begin
        rdata_q <= data_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign sfr_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the lock sequence.
  unlock_order_a: assert property ( // R1
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (lock_q == LOCK_FIRST && key_wr && sfr_wdata_i == RTCLI_KEY_SECOND)
    |=> lock_q == LOCK_OPEN)
    else $error("second key did not unlock");

  bad_key_a: assert property ( // R3
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (lock_q == LOCK_IDLE && key_wr && sfr_wdata_i != RTCLI_KEY_FIRST)
    |=> lock_q == LOCK_DEAD)
    else $error("wrong first key did not disable");

  dead_stays_a: assert property ( // R3
    @(posedge clk_i) disable iff (!rst_n_i)
    lock_q == LOCK_DEAD |-> !start ##1 lock_q == LOCK_DEAD)
    else $error("disabled interface left its state or accepted access");

  relock_a: assert property ( // R5
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (is_open && key_wr) |=> lock_q == LOCK_IDLE && !is_open)
    else $error("key write did not relock");

  status_read_a: assert property ( // R6
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    key_rd |=> $stable(lock_q) && rdata_q == key_view)
    else $error("status read disturbed the sequence");

  ////////////////////////////////////////////////////////////////////////
  // Checks on indirect access timing and data.
  short_len_a: assert property ( // R13
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (start && short_nx) |=> busy_q [*6] ##1 !busy_q)
    else $error("short strobe access not six cycles");

  long_len_a: assert property ( // R13
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (start && !short_nx) |=> busy_q [*7] ##1 !busy_q)
    else $error("normal access not seven cycles");

  read_copy_a: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (xfer && !op_wr_q) |=> data_q == $past(bank_if.rdata))
    else $error("indirect read did not reach data port");

  data_hold_a: assert property ( // R10
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (!wr_start && !(xfer && !op_wr_q)) |=> $stable(data_q))
    else $error("data port changed without an access");

  auto_inc_a: assert property ( // R18
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (xfer && auto_inc) |=> addr_q == $past(addr_q) + 4'h1)
    else $error("address did not increment");

  autoread_a: assert property ( // R15
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (dat_rd && idle_open && auto_q) |=> busy_q && !op_wr_q)
    else $error("autoread did not start a read");

endmodule : rtcli_top

// File: verification/rtcli_host_model.sv
`timescale 1ns/1ps
// Host core model that drives the special function register bus.
module rtcli_host_model
  import rtcli_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] sfr_rdata_i,
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [7:0] sfr_wdata_o
);

  // The bus starts idle with both strobes low.
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One write strobe; released lines are inverted so stale values never pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_o <= a;
    sfr_wdata_o <= d;
    sfr_wr_o <= 1'b1;
    @(posedge clk_i);
    sfr_wr_o <= 1'b0;
    sfr_addr_o <= ~a;
    sfr_wdata_o <= ~d;
  endtask : wr

  // One read strobe; the answer is taken one cycle after the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_o <= a;
    sfr_rd_o <= 1'b1;
    @(posedge clk_i);
    sfr_rd_o <= 1'b0;
    sfr_addr_o <= ~a;
    @(posedge clk_i);
    d = sfr_rdata_i;
  endtask : rd

  // busy poll spacing
  // Polls the address port until busy is low, bounded to sixteen reads.
  task automatic poll(output logic [7:0] v);
    v = 8'hFF;
    for (int n = 0; n < 16 && v[RTCLI_BUSY_BIT] !== 1'b0; n++) begin
      rd(RTCLI_ADR_ADDR, v);
    end
  endtask : poll

endmodule : rtcli_host_model

// File: verification/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the locked indirect access block.
module testbench
  import rtcli_pkg::*;
;
  logic clk_i;
  logic rst_n_i;
  logic por_n_i;
  logic ce_i;
  logic capture_i;
  logic [31:0] counter_i;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [31:0] snap;
  logic [7:0] cc;
  logic [7:0] oc;
  logic [7:0] ocf;
  logic [7:0] pc;
  logic [31:0] alarm;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  // Design under test and the host model on its register bus.
  rtcli_top rtcli_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
    .ce_i(ce_i), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
    .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .capture_i(capture_i),
    .counter_i(counter_i), .counter_snapshot_o(snap), .clock_control_o(cc),
    .oscillator_control_o(oc), .oscillator_config_o(ocf),
    .pin_config_o(pc), .alarm_value_o(alarm));
  rtcli_host_model host_i (.clk_i(clk_i), .sfr_rdata_i(sfr_rdata),
    .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd),
    .sfr_wdata_o(sfr_wdata));

  // System clock of 100 MHz.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Cuts a hang short well after the expected run length.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares a byte and counts the result.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk8

  // Compares a 32-bit word and counts the result.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk32

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("miscompares=%0d check_count=%0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Pulses the system reset only; address, autoread and data must survive it, while the short bit returns to one.
  task automatic sys_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask : sys_reset

  ////////////////////////////////////////////////////////////////////////////
  // Each misuse disables the interface, and unlocking no longer helps.
  task automatic t_bad(input int mode);
    logic [7:0] v;
    sys_reset();
    if (mode == 0) begin
      host_i.rd(RTCLI_ADR_ADDR, v);
    end else if (mode == 1) begin
      host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_SECOND);
    end else begin
      host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_FIRST);
      host_i.wr(RTCLI_KEY_ADDR, 8'h00);
    end
    host_i.rd(RTCLI_KEY_ADDR, v);
    chk8(v, RTCLI_ST_DISABLED);
    host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_FIRST);
    host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_SECOND);
    host_i.rd(RTCLI_KEY_ADDR, v);
    chk8(v, RTCLI_ST_DISABLED);
    host_i.rd(RTCLI_ADR_ADDR, v);
    chk8(v, 8'h00);
  endtask : t_bad

  // Unlock with status reads between keys and a long gap.
  task automatic t_unlock();
    logic [7:0] v;
    sys_reset();
    host_i.rd(RTCLI_KEY_ADDR, v);
    chk8(v, RTCLI_ST_LOCKED);
    host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_FIRST);
    host_i.rd(RTCLI_KEY_ADDR, v);
    chk8(v, RTCLI_ST_FIRST);
    repeat (50) @(posedge clk_i);
    host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_SECOND);
    host_i.rd(RTCLI_KEY_ADDR, v);
    chk8(v, RTCLI_ST_OPEN);
    host_i.rd(RTCLI_ADR_ADDR, v);
    chk8(v, 8'h10);
  endtask : t_unlock

  // Cycles from the data write edge to the bank update, short then long.
  task automatic t_timing();
    logic [7:0] v;
    logic [7:0] e;
    logic [7:0] n;
    for (int s = 0; s < 2; s++) begin
      e = (s == 0) ? 8'h5A : 8'hA5;
      host_i.wr(RTCLI_ADR_ADDR, (s == 0) ? 8'h14 : 8'h04);
      host_i.wr(RTCLI_DAT_ADDR, e);
      n = 8'h00;
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while (cc !== e && n < 8'h14);
      chk8(n, (s == 0) ? 8'h06 : 8'h07);
      host_i.poll(v);
      chk8(v, (s == 0) ? 8'h14 : 8'h04);
    end
  endtask : t_timing

  // Writes control bytes 4..7, reads one back, probes an unmapped address.
  task automatic t_rdwr();
    logic [7:0] v;
    for (int i = 4; i < 8; i++) begin
      host_i.wr(RTCLI_ADR_ADDR, 8'h10 | 8'(i));
      host_i.wr(RTCLI_DAT_ADDR, 8'h40 | 8'(i));
      host_i.poll(v);
    end
    chk8(cc, 8'h44);
    chk8(oc, 8'h45);
    chk8(ocf, 8'h46);
    chk8(pc, 8'h47);
    host_i.wr(RTCLI_ADR_ADDR, 8'h95);
    host_i.rd(RTCLI_ADR_ADDR, v);
    chk8(v, 8'h95);
    host_i.poll(v);
    chk8(v, 8'h15);
    host_i.rd(RTCLI_DAT_ADDR, v);
    chk8(v, 8'h45);
    host_i.rd(RTCLI_DAT_ADDR, v);
    chk8(v, 8'h45);
    host_i.wr(8'h04, 8'hEE);
    host_i.rd(8'h04, v);
    chk8(v, 8'h00);
    chk8(cc, 8'h44);
  endtask : t_rdwr

  // Auto-increment over snapshot and alarm bytes, then an autoread series.
  task automatic t_auto();
    logic [7:0] v;
    logic [7:0] d;
    host_i.wr(RTCLI_ADR_ADDR, 8'h10);
    for (int k = 0; k < 4; k++) begin
      host_i.wr(RTCLI_DAT_ADDR, 8'(17 * (k + 1)));
      host_i.poll(v);
    end
    chk32(snap, 32'h44332211);
    chk8(v, 8'h14);
    host_i.wr(RTCLI_ADR_ADDR, 8'h18);
    for (int k = 0; k < 4; k++) begin
      host_i.wr(RTCLI_DAT_ADDR, 8'hA0 | 8'(k));
      host_i.poll(v);
    end
    chk32(alarm, 32'hA3A2A1A0);
    chk8(v, 8'h1C);
    host_i.wr(RTCLI_ADR_ADDR, 8'hD8);
    host_i.poll(v);
    chk8(v, 8'h59);
    for (int k = 0; k < 4; k++) begin
      host_i.rd(RTCLI_DAT_ADDR, d);
      chk8(d, 8'hA0 | 8'(k));
      host_i.poll(v);
      chk8(v, (k < 3) ? 8'h5A + 8'(k) : 8'h5C);
    end
    // A capture pulse loads the snapshot bytes, read back indirectly.
    @(posedge clk_i);
    counter_i <= 32'hC3B2A187;
    capture_i <= 1'b1;
    @(posedge clk_i);
    capture_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk32(snap, 32'hC3B2A187);
    host_i.wr(RTCLI_ADR_ADDR, 8'h90);
    host_i.poll(v);
    chk8(v, 8'h11);
    host_i.rd(RTCLI_DAT_ADDR, d);
    chk8(d, 8'h87);
  endtask : t_auto

  // Frozen key write, relock, then a system reset that keeps address and data but sets the short bit.
  task automatic t_relock();
    logic [7:0] v;
    host_i.wr(RTCLI_ADR_ADDR, 8'h06);
    host_i.wr(RTCLI_DAT_ADDR, 8'h77);
    host_i.poll(v);
    chk8(v, 8'h06);
    chk8(ocf, 8'h77);
    // A key write while the clock enable is low must not relock.
    @(posedge clk_i);
    ce_i <= 1'b0;
    host_i.wr(RTCLI_KEY_ADDR, 8'h00);
    ce_i <= 1'b1;
    host_i.rd(RTCLI_KEY_ADDR, v);
    chk8(v, RTCLI_ST_OPEN);
    host_i.wr(RTCLI_KEY_ADDR, 8'h00);
    host_i.rd(RTCLI_KEY_ADDR, v);
    chk8(v, RTCLI_ST_LOCKED);
    sys_reset();
    host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_FIRST);
    host_i.wr(RTCLI_KEY_ADDR, RTCLI_KEY_SECOND);
    host_i.rd(RTCLI_ADR_ADDR, v);
    chk8(v, 8'h16);
    host_i.rd(RTCLI_DAT_ADDR, v);
    chk8(v, 8'h77);
  endtask : t_relock

  ////////////////////////////////////////////////////////////////////////////
  // Power-up reset of both domains, then the scenarios in order.
  initial begin
    rst_n_i = 1'b0;
    por_n_i = 1'b0;
    ce_i = 1'b1;
    capture_i = 1'b0;
    counter_i = 32'h00000000;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      t_bad(m);
    end
    t_unlock();
    t_timing();
    t_rdwr();
    t_auto();
    t_relock();
    conclude();
  end

endmodule : testbench
